/* pkg/tsr_consts.svh */
// Register field positions, reset values and fault-count constants.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

`define TSR_CFG_SHDN   0
`define TSR_CFG_MODE   1
`define TSR_CFG_POL    2
`define TSR_CFG_FQ_LO  3
`define TSR_CFG_FQ_HI  4
`define TSR_VAL_LSB    7
`define TSR_CFG_RST    8'h00
`define TSR_SEL_RST    8'h00
`define TSR_TEMP_RST   9'h000
`define TSR_TRIP_RST   9'h0a0
`define TSR_REL_RST    9'h096
`define TSR_FQ_1       3'h1
`define TSR_FQ_2       3'h2
`define TSR_FQ_4       3'h4
`define TSR_FQ_6       3'h6
`define TSR_CNT_MAX    3'h7

`endif

/* pkg/tsr_pkg.sv */
// Types shared by the temperature sensor register bank and its link port.
package tsr_pkg;

    // Register chosen by the selector low bits
    typedef enum logic [1:0] {
        TSR_R_TEMP = 2'h0,
        TSR_R_CFG  = 2'h1,
        TSR_R_REL  = 2'h2,
        TSR_R_TRIP = 2'h3
    } tsr_reg_t;

    // Event carried from the link domain
    typedef enum logic [1:0] {
        TSR_EV_START_WR = 2'h0,
        TSR_EV_START_RD = 2'h1,
        TSR_EV_WR       = 2'h2,
        TSR_EV_RD       = 2'h3
    } tsr_evt_t;

    // Link port handshake state
    typedef enum logic {
        TSR_LK_IDLE = 1'b0,
        TSR_LK_WAIT = 1'b1
    } tsr_lk_state_t;

    typedef struct packed {
        logic          rst_m;
        logic          rst_s;
        tsr_lk_state_t st;
        logic          busy;
        logic          req_tgl;
        tsr_evt_t      kind;
        logic [7:0]    data;
        logic          ack_m;
        logic          ack_s;
        logic          ack_seen;
        logic          rd_valid;
        logic [7:0]    rd_byte;
    } tsr_lk_t;

    typedef struct packed {
        logic       req_s1;
        logic       req_s2;
        logic       req_s3;
        logic [7:0] sel;
        logic [7:0] cfg;
        logic [8:0] temp;
        logic [8:0] trip;
        logic [8:0] rel;
        logic [7:0] stage;
        logic [1:0] idx;
        logic       ack_tgl;
        logic [7:0] ack_data;
        logic [2:0] filt_cnt;
        logic       filt_dir;
        logic       hot;
        logic       alert_lat;
        logic       alert_out;
        logic       alert_oe;
        logic       halt;
    } tsr_main_t;

endpackage

/* src/tsr_link_port.sv */
// Link-side agent: turns byte events into a toggle handshake to the system clock.
`timescale 1ns/1ps
`default_nettype none

module tsr_link_port (
    input  wire logic            link_clk,
    input  wire logic            rst,
    input  wire logic            lk_start,
    input  wire logic            lk_read,
    input  wire logic            lk_wr_valid,
    input  wire logic [7:0]      lk_wr_byte,
    input  wire logic            lk_rd_req,
    output logic                 lk_busy,
    output logic                 lk_rd_valid,
    output logic [7:0]           lk_rd_byte,
    output logic                 req_tgl,
    output tsr_pkg::tsr_evt_t    req_kind,
    output logic [7:0]           req_data,
    input  wire logic            ack_tgl,
    input  wire logic [7:0]      ack_data
);

    tsr_pkg::tsr_lk_t s;
    tsr_pkg::tsr_lk_t n;

    // Capture one event, hold it stable, wait for the returned toggle
    always_comb begin
        n          = s;
        n.rst_m    = rst;
        n.rst_s    = s.rst_m;
        n.ack_m    = ack_tgl;
        n.ack_s    = s.ack_m;
        n.rd_valid = 1'b0;
        unique case (s.st)
            tsr_pkg::TSR_LK_IDLE: begin
                if (lk_start || lk_wr_valid || lk_rd_req) begin
                    n.st      = tsr_pkg::TSR_LK_WAIT;
                    n.busy    = 1'b1;
                    n.req_tgl = ~s.req_tgl;
                    n.data    = lk_wr_byte;
                    if (lk_start) begin
                        n.kind = lk_read ? tsr_pkg::TSR_EV_START_RD : tsr_pkg::TSR_EV_START_WR;
                    end else if (lk_wr_valid) begin
                        n.kind = tsr_pkg::TSR_EV_WR;
                    end else begin
                        n.kind = tsr_pkg::TSR_EV_RD;
                    end
                end
            end
            tsr_pkg::TSR_LK_WAIT: begin
                if (s.ack_s != s.ack_seen) begin
                    n.st       = tsr_pkg::TSR_LK_IDLE;
                    n.busy     = 1'b0;
                    n.ack_seen = s.ack_s;
                    if (s.kind == tsr_pkg::TSR_EV_RD) begin
                        n.rd_valid = 1'b1;
                        n.rd_byte  = ack_data; // Held stable since the toggle moved
                    end
                end
            end
        endcase
    end

    // Link reset comes through its own two-flop synchroniser
    always_ff @(posedge link_clk) begin
        if (s.rst_s) begin
            s          <= '0;
            s.rst_m    <= rst;
            s.rst_s    <= s.rst_m;
            s.st       <= tsr_pkg::TSR_LK_IDLE;
            s.kind     <= tsr_pkg::TSR_EV_START_WR;
        end else begin
            s <= n;
        end
    end

    assign lk_busy     = s.busy;
    assign lk_rd_valid = s.rd_valid;
    assign lk_rd_byte  = s.rd_byte;
    assign req_tgl     = s.req_tgl;
    assign req_kind    = s.kind;
    assign req_data    = s.data;

endmodule // tsr_link_port

`default_nettype wire

/* src/tsr_sensor_regs.sv */
// Temperature sensor register bank, fault filter and alert output.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.svh"

module tsr_sensor_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        link_clk,
    input  wire logic        lk_start,
    input  wire logic        lk_read,
    input  wire logic        lk_wr_valid,
    input  wire logic [7:0]  lk_wr_byte,
    input  wire logic        lk_rd_req,
    output logic             lk_busy,
    output logic             lk_rd_valid,
    output logic [7:0]       lk_rd_byte,
    input  wire logic        conv_valid,
    input  wire logic [8:0]  conv_temp,
    output logic             conv_halt,
    output logic             alert_output,
    output logic             alert_output_oe
);

    tsr_pkg::tsr_main_t  s;
    tsr_pkg::tsr_main_t  n;
    logic                req_tgl;
    tsr_pkg::tsr_evt_t   req_kind;
    logic [7:0]          req_data;
    logic                ev;
    tsr_pkg::tsr_reg_t   cur;
    logic [15:0]         word;
    logic [7:0]          rd_byte;
    logic                conv_go;
    logic                above;
    logic                below;
    logic [2:0]          need;
    logic                shdn_entry;
    logic                active;

    // Link-domain agent
    tsr_link_port u_link (
        .link_clk    (link_clk),
        .rst         (rst),
        .lk_start    (lk_start),
        .lk_read     (lk_read),
        .lk_wr_valid (lk_wr_valid),
        .lk_wr_byte  (lk_wr_byte),
        .lk_rd_req   (lk_rd_req),
        .lk_busy     (lk_busy),
        .lk_rd_valid (lk_rd_valid),
        .lk_rd_byte  (lk_rd_byte),
        .req_tgl     (req_tgl),
        .req_kind    (req_kind),
        .req_data    (req_data),
        .ack_tgl     (s.ack_tgl),
        .ack_data    (s.ack_data)
    );

    // Selector low bits to register
    function automatic tsr_pkg::tsr_reg_t tsr_pick(input logic [7:0] sel);
        return tsr_pkg::tsr_reg_t'(sel[1:0]);
    endfunction

    // Fault count from configuration bits 4:3
    function automatic logic [2:0] tsr_need(input logic [7:0] cfg);
        logic [2:0] r;
        unique case (cfg[`TSR_CFG_FQ_HI:`TSR_CFG_FQ_LO])
            2'h0: r = `TSR_FQ_1;
            2'h1: r = `TSR_FQ_2;
            2'h2: r = `TSR_FQ_4;
            2'h3: r = `TSR_FQ_6;
        endcase
        return r;
    endfunction

    // Nine-bit value left-justified in a 16-bit word
    function automatic logic [15:0] tsr_word(input logic [8:0] v);
        return {v, 7'h00};
    endfunction

    // Power-up contents
    localparam tsr_pkg::tsr_main_t RST_VAL = '{
        req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0,
        sel: `TSR_SEL_RST, cfg: `TSR_CFG_RST, temp: `TSR_TEMP_RST,
        trip: `TSR_TRIP_RST, rel: `TSR_REL_RST, stage: 8'h00, idx: 2'h0,
        ack_tgl: 1'b0, ack_data: 8'h00, filt_cnt: 3'h0, filt_dir: 1'b0,
        hot: 1'b0, alert_lat: 1'b0, alert_out: 1'b1, alert_oe: 1'b0, halt: 1'b0
    };

    // Register bank, filter and alert next state
    always_comb begin
        n          = s;
        n.req_s1   = req_tgl;
        n.req_s2   = s.req_s1;
        n.req_s3   = s.req_s2;
        ev         = s.req_s2 ^ s.req_s3;
        cur        = tsr_pick(s.sel);
        need       = tsr_need(s.cfg);
        shdn_entry = 1'b0;

        // Read byte of the selected register
        unique case (cur)
            tsr_pkg::TSR_R_TEMP: word = tsr_word(s.temp);
            tsr_pkg::TSR_R_CFG:  word = {s.cfg, s.cfg};
            tsr_pkg::TSR_R_REL:  word = tsr_word(s.rel);
            tsr_pkg::TSR_R_TRIP: word = tsr_word(s.trip);
        endcase
        if (cur == tsr_pkg::TSR_R_CFG) begin
            rd_byte = s.cfg;
        end else begin
            rd_byte = (s.idx == 2'h0) ? word[15:8] : word[7:0];
        end

        // Link events
        if (ev) begin
            n.ack_tgl = ~s.ack_tgl;
            unique case (req_kind)
                tsr_pkg::TSR_EV_START_WR, tsr_pkg::TSR_EV_START_RD: begin
                    n.idx = 2'h0;
                end
                tsr_pkg::TSR_EV_WR: begin
                    if (s.idx == 2'h0) begin
                        n.sel = req_data;
                    end else begin
                        unique case (cur)
                            tsr_pkg::TSR_R_TEMP: n.stage = s.stage;
                            tsr_pkg::TSR_R_CFG: begin
                                n.cfg      = req_data;
                                shdn_entry = req_data[`TSR_CFG_SHDN] & ~s.cfg[`TSR_CFG_SHDN];
                            end
                            tsr_pkg::TSR_R_REL, tsr_pkg::TSR_R_TRIP: begin
                                if (s.idx == 2'h1) begin
                                    n.stage = req_data;
                                end else if (s.idx == 2'h2) begin
                                    if (cur == tsr_pkg::TSR_R_REL) begin
                                        n.rel = {s.stage, req_data[`TSR_VAL_LSB]};
                                    end else begin
                                        n.trip = {s.stage, req_data[`TSR_VAL_LSB]};
                                    end
                                end
                            end
                        endcase
                    end
                    if (s.idx != 2'h3) begin
                        n.idx = s.idx + 2'h1;
                    end
                end
                tsr_pkg::TSR_EV_RD: begin
                    n.ack_data = rd_byte;
                    if (s.idx != 2'h3) begin
                        n.idx = s.idx + 2'h1;
                    end
                end
            endcase
        end

        // Conversion results and fault filter; halted in shutdown
        conv_go = conv_valid & ~s.cfg[`TSR_CFG_SHDN];
        above   = $signed(conv_temp) > $signed(s.trip);
        below   = $signed(conv_temp) < $signed(s.rel);
        if (conv_go) begin
            n.temp = conv_temp;
            if (above || below) begin
                if ((above == s.filt_dir) && (s.filt_cnt != 3'h0)) begin
                    n.filt_cnt = (s.filt_cnt == `TSR_CNT_MAX) ? `TSR_CNT_MAX
                                                              : s.filt_cnt + 3'h1;
                end else begin
                    n.filt_cnt = 3'h1;
                end
                n.filt_dir = above;
                if (n.filt_cnt >= need) begin
                    n.hot = above;
                end
            end else begin
                n.filt_cnt = 3'h0;
            end
        end

        // Interrupt latch: cleared by any read or by shutdown entry in interrupt mode; set wins
        if (ev && (req_kind == tsr_pkg::TSR_EV_RD)) begin
            n.alert_lat = 1'b0;
        end
        if (shdn_entry && s.cfg[`TSR_CFG_MODE]) begin
            n.alert_lat = 1'b0;
        end
        if (s.cfg[`TSR_CFG_MODE] && (n.hot != s.hot)) begin
            n.alert_lat = 1'b1;
        end

        // Alert level and open-drain enable
        active      = n.cfg[`TSR_CFG_MODE] ? n.alert_lat : n.hot;
        n.alert_out = n.cfg[`TSR_CFG_POL] ? active : ~active;
        n.alert_oe  = ~n.alert_out;
        n.halt      = n.cfg[`TSR_CFG_SHDN];
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= RST_VAL;
        end else begin
            s <= n;
        end
    end

    assign conv_halt       = s.halt;
    assign alert_output    = s.alert_out;
    assign alert_output_oe = s.alert_oe;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sel_write_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_WR && s.idx == 2'h0) |=> (s.sel == $past(req_data))
    ) else $error("selector not loaded from first write byte");

    cfg_write_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_WR && s.idx == 2'h1 && cur == tsr_pkg::TSR_R_CFG)
        |=> (s.cfg == $past(req_data)) ##1 (conv_halt == s.cfg[`TSR_CFG_SHDN])
    ) else $error("configuration write or shutdown output wrong");

    temp_load_a: assert property (
        (conv_valid && !s.cfg[`TSR_CFG_SHDN]) |=> (s.temp == $past(conv_temp))
    ) else $error("temperature not refreshed by conversion");

    shdn_hold_a: assert property (
        (s.cfg[`TSR_CFG_SHDN] && $past(s.cfg[`TSR_CFG_SHDN])) |-> ($stable(s.temp) && $stable(s.hot))
    ) else $error("conversion acted during shutdown");

    comp_level_a: assert property (
        (!s.cfg[`TSR_CFG_MODE]) |-> (alert_output == (s.cfg[`TSR_CFG_POL] ? s.hot : ~s.hot))
    ) else $error("comparator alert level wrong");

    int_clear_a: assert property (
        (s.cfg[`TSR_CFG_MODE] && ev && req_kind == tsr_pkg::TSR_EV_RD && n.hot == s.hot)
        |=> (!s.alert_lat && (alert_output == !s.cfg[`TSR_CFG_POL]))
    ) else $error("interrupt latch not cleared by read");

    filter_run_a: assert property (
        $changed(s.hot) |-> (s.filt_cnt >= tsr_need($past(s.cfg)))
    ) else $error("alert changed before fault count reached");

    pol_oe_a: assert property (
        (alert_output_oe == ~alert_output)
        and (s.cfg[`TSR_CFG_MODE] |-> (alert_output == (s.cfg[`TSR_CFG_POL] == s.alert_lat)))
    ) else $error("alert polarity or enable wrong");

    msb_first_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_RD && s.idx == 2'h0 && cur == tsr_pkg::TSR_R_TRIP)
        |=> (s.ack_data == $past(s.trip[8:1]))
    ) else $error("trip read did not start with high byte");

    // Low byte of a threshold carries the value LSB in bit 7
    trip_low_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_RD && s.idx == 2'h1 && cur == tsr_pkg::TSR_R_TRIP)
        |=> (s.ack_data == {$past(s.trip[0]), 7'h00})
    ) else $error("trip read low byte wrong");

    cfg_read_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_RD && cur == tsr_pkg::TSR_R_CFG)
        |=> (s.ack_data == $past(s.cfg))
    ) else $error("configuration read byte wrong");

    // Release value committed at the low byte from the staged high byte
    rel_commit_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_WR && s.idx == 2'h2 && cur == tsr_pkg::TSR_R_REL)
        |=> (s.rel == {$past(s.stage), $past(req_data[`TSR_VAL_LSB])})
    ) else $error("release threshold not committed");

    temp_ro_a: assert property (
        (ev && req_kind == tsr_pkg::TSR_EV_WR && s.idx != 2'h0 && cur == tsr_pkg::TSR_R_TEMP
         && !conv_valid) |=> $stable(s.temp)
    ) else $error("temperature register took a host write");

    // Shutdown entry in interrupt mode drops the latch
    shdn_clear_a: assert property (
        (s.cfg[`TSR_CFG_MODE] && ev && req_kind == tsr_pkg::TSR_EV_WR && s.idx != 2'h0
         && cur == tsr_pkg::TSR_R_CFG && req_data[`TSR_CFG_SHDN] && !s.cfg[`TSR_CFG_SHDN]
         && n.hot == s.hot) |=> (!s.alert_lat)
    ) else $error("shutdown entry did not clear interrupt latch");

    // A result between the thresholds never moves the alert state
    band_hold_a: assert property (
        (conv_valid && !s.cfg[`TSR_CFG_SHDN] && $signed(conv_temp) <= $signed(s.trip)
         && $signed(conv_temp) >= $signed(s.rel)) |=> $stable(s.hot)
    ) else $error("alert state moved inside the band");

    sel_keep_a: assert property (
        (ev && req_kind != tsr_pkg::TSR_EV_WR) |=> $stable(s.sel)
    ) else $error("selector changed without a write");

    reset_val_a: assert property (
        $fell(rst) |-> (s.trip == `TSR_TRIP_RST && s.rel == `TSR_REL_RST
                        && s.cfg == `TSR_CFG_RST && alert_output)
    ) else $error("power-up values wrong");

endmodule // tsr_sensor_regs

`default_nettype wire

/* dv/tsr_host_model.sv */
// Host model: gates the link clock per frame and drives link strobes.
`timescale 1ns/1ps
`default_nettype none

module tsr_host_model (
    output logic       link_clk,
    output logic       lk_start,
    output logic       lk_read,
    output logic       lk_wr_valid,
    output logic [7:0] lk_wr_byte,
    output logic       lk_rd_req,
    input  wire logic  lk_busy,
    output logic       stall
);
    logic run = 1'b1;

    // Link clock, 80 ns, odd phase; runs until the first frame ends, then stands still between frames
    initial begin
        link_clk = 1'b0;
        #13;
        forever begin
            #40;
            if (run || link_clk) begin
                link_clk = ~link_clk;
            end
        end
    end

    // Quiet strobes at time zero
    initial begin
        lk_start    = 1'b0;
        lk_read     = 1'b0;
        lk_wr_valid = 1'b0;
        lk_wr_byte  = 8'h5a;
        lk_rd_req   = 1'b0;
        stall       = 1'b0;
    end

    // One strobe: 0 start write, 1 start read, 2 byte, 3 read request
    task automatic strobe(input logic [1:0] kind, input logic [7:0] b);
        int n;
        n = 0;
        @(posedge link_clk);
        lk_start    <= ~kind[1];
        lk_read     <= kind[0] & ~kind[1];
        lk_wr_valid <= (kind == 2'h2);
        lk_wr_byte  <= (kind == 2'h2) ? b : ~lk_wr_byte;
        lk_rd_req   <= (kind == 2'h3);
        @(posedge link_clk);
        lk_start    <= 1'b0;
        lk_wr_valid <= 1'b0;
        lk_rd_req   <= 1'b0;
        lk_wr_byte  <= ~lk_wr_byte;
        do begin
            @(negedge link_clk);
            n++;
        end while (lk_busy !== 1'b0 && n < 20);
        if (n >= 20) begin
            stall <= 1'b1;
        end
    endtask

    // Whole frame: write sends selector then nb bytes, read asks nb bytes
    task automatic frame(input logic rd, input logic [1:0] sel, input int nb,
                         input logic [15:0] v);
        int i;
        run = 1'b1;
        strobe({1'b0, rd}, 8'h00);
        if (!rd) begin
            strobe(2'h2, {6'h00, sel});
        end
        for (i = 0; i < nb; i++) begin
            if (rd) begin
                strobe(2'h3, 8'h00);
            end else begin
                strobe(2'h2, (nb - i == 2) ? v[15:8] : v[7:0]);
            end
        end
        @(posedge link_clk);
        run = 1'b0;
    endtask
endmodule // tsr_host_model

`default_nettype wire

/* dv/tsr_sensor_regs_tb.sv */
// Testbench of the temperature sensor register bank.
`timescale 1ns/1ps
`default_nettype none

module tsr_sensor_regs_tb;
    logic       sys_clk;
    logic       rst;
    logic       link_clk;
    logic       lk_start;
    logic       lk_read;
    logic       lk_wr_valid;
    logic [7:0] lk_wr_byte;
    logic       lk_rd_req;
    logic       lk_busy;
    logic       lk_rd_valid;
    logic [7:0] lk_rd_byte;
    logic       conv_valid;
    logic [8:0] conv_temp;
    logic       conv_halt;
    logic       alert_output;
    logic       alert_output_oe;
    logic       host_stall;
    logic [7:0] exp_q[$];
    logic [7:0] exp_b;
    logic [8:0] v9;
    logic [6:0] junk;
    int         seed;
    int         i;
    int         k;
    int         n;
    int         n_errors = 0;
    int         checked = 0;

    tsr_sensor_regs dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .lk_start(lk_start), .lk_read(lk_read), .lk_wr_valid(lk_wr_valid),
        .lk_wr_byte(lk_wr_byte), .lk_rd_req(lk_rd_req), .lk_busy(lk_busy),
        .lk_rd_valid(lk_rd_valid), .lk_rd_byte(lk_rd_byte), .conv_valid(conv_valid),
        .conv_temp(conv_temp), .conv_halt(conv_halt), .alert_output(alert_output),
        .alert_output_oe(alert_output_oe));

    tsr_host_model host (.link_clk(link_clk), .lk_start(lk_start), .lk_read(lk_read),
        .lk_wr_valid(lk_wr_valid), .lk_wr_byte(lk_wr_byte), .lk_rd_req(lk_rd_req),
        .lk_busy(lk_busy), .stall(host_stall));

    // System clock, 100 ns
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask

    // Repoint, then read nb bytes; expected bytes noted first
    task automatic rd_reg(input logic [1:0] sel, input int nb, input logic [15:0] v);
        if (nb == 2) begin
            exp_q.push_back(v[15:8]);
        end
        exp_q.push_back(v[7:0]);
        host.frame(1'b0, sel, 0, 16'h0000);
        host.frame(1'b1, sel, nb, 16'h0000);
    endtask

    task automatic set_cfg(input logic [7:0] c);
        host.frame(1'b0, 2'h1, 1, {8'h00, c});
    endtask

    // One conversion result, then data line scrambled
    task automatic conv(input logic [8:0] t);
        @(posedge sys_clk);
        conv_valid <= 1'b1;
        conv_temp  <= t;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        conv_temp  <= ~t;
        repeat (2) @(posedge sys_clk);
    endtask

    // Pin level from asserted state and polarity
    task automatic chk_alert(input logic act, input logic pol);
        @(negedge sys_clk);
        cmp_bit("alert_output", ~(act ^ pol), alert_output);
        cmp_bit("alert_output_oe", act ^ pol, alert_output_oe);
    endtask

    // Read answers matched against the oldest note
    always @(negedge link_clk) begin
        if (lk_rd_valid === 1'b1) begin
            exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            cmp_byte("lk_rd_byte", exp_b, lk_rd_byte);
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #3000000;
        n_errors++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        report_and_stop();
    end

    // Main sequence
    initial begin
        seed = 50;
        rst = 1'b1;
        conv_valid = 1'b0;
        conv_temp = 9'h000;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk_alert(1'b0, 1'b0);
        cmp_bit("conv_halt", 1'b0, conv_halt);
        rd_reg(2'h1, 1, 16'h0000);
        rd_reg(2'h3, 2, {9'h0a0, 7'h00});
        rd_reg(2'h2, 2, {9'h096, 7'h00});
        rd_reg(2'h0, 2, 16'h0000);
        $display("test reset_values done");
        for (i = 0; i < 6; i++) begin
            v9 = 9'($random(seed));
            junk = 7'($random(seed));
            host.frame(1'b0, {1'b1, i[0]}, 2, {v9, junk});
            rd_reg({1'b1, i[0]}, 2, {v9, 7'h00});
        end
        $display("test thresholds done");
        for (i = 0; i < 4; i++) begin
            v9 = (i == 0) ? 9'h1ce : (i == 1) ? 9'h0fa : (i == 2) ? 9'h1ff : 9'h001;
            conv(v9);
            rd_reg(2'h0, 2, {v9, 7'h00});
        end
        host.frame(1'b0, 2'h0, 2, 16'h1234);
        rd_reg(2'h0, 2, {9'h001, 7'h00});
        $display("test temperature done");
        host.frame(1'b0, 2'h3, 2, {9'h004, 7'h00});
        host.frame(1'b0, 2'h2, 2, {9'h1fc, 7'h00});
        conv(9'h1f0);
        chk_alert(1'b0, 1'b0);
        conv(9'h004);
        chk_alert(1'b0, 1'b0);
        conv(9'h005);
        chk_alert(1'b1, 1'b0);
        conv(9'h1fc);
        chk_alert(1'b1, 1'b0);
        conv(9'h1fb);
        chk_alert(1'b0, 1'b0);
        set_cfg(8'h04);
        chk_alert(1'b0, 1'b1);
        conv(9'h005);
        chk_alert(1'b1, 1'b1);
        conv(9'h1f0);
        chk_alert(1'b0, 1'b1);
        $display("test comparator done");
        for (k = 0; k < 4; k++) begin
            n = (k == 3) ? 6 : (1 << k);
            set_cfg({3'b000, k[1:0], 3'b000});
            rd_reg(2'h1, 1, {8'h00, 3'b000, k[1:0], 3'b000});
            repeat (n - 1) conv(9'h005);
            conv(9'h000);
            repeat (n - 1) conv(9'h005);
            chk_alert(1'b0, 1'b0);
            conv(9'h005);
            chk_alert(1'b1, 1'b0);
            repeat (n - 1) conv(9'h1f0);
            chk_alert(1'b1, 1'b0);
            conv(9'h1f0);
            chk_alert(1'b0, 1'b0);
        end
        $display("test fault_filter done");
        set_cfg(8'h00);
        conv(9'h005);
        set_cfg(8'h01);
        @(negedge sys_clk);
        cmp_bit("conv_halt", 1'b1, conv_halt);
        conv(9'h1f0);
        chk_alert(1'b1, 1'b0);
        rd_reg(2'h0, 2, {9'h005, 7'h00});
        host.frame(1'b0, 2'h2, 2, {9'h1f8, 7'h00});
        rd_reg(2'h2, 2, {9'h1f8, 7'h00});
        set_cfg(8'h00);
        conv(9'h1f0);
        set_cfg(8'h02);
        rd_reg(2'h1, 1, 16'h0002);
        chk_alert(1'b0, 1'b0);
        conv(9'h005);
        chk_alert(1'b1, 1'b0);
        conv(9'h000);
        chk_alert(1'b1, 1'b0);
        rd_reg(2'h0, 2, {9'h000, 7'h00});
        chk_alert(1'b0, 1'b0);
        conv(9'h1f0);
        chk_alert(1'b1, 1'b0);
        set_cfg(8'h03);
        chk_alert(1'b0, 1'b0);
        $display("test shutdown_interrupt done");
        repeat (4) @(posedge sys_clk);
        cmp_bit("read notes drained", 1'b1, exp_q.size() == 0);
        cmp_bit("host handshake stall", 1'b0, host_stall);
        report_and_stop();
    end
endmodule // tsr_sensor_regs_tb

`default_nettype wire
